// ===== uhpc_defs.vh
// Constants for the host port control block: offsets, fields, codes.
// Assumes a plain register port with 8-bit byte addresses and 32-bit data.
`ifndef UHPC_DEFS_VH
`define UHPC_DEFS_VH
// Register offsets
`define UHPC_REG_POWER 8'h00
`define UHPC_REG_BUSCTL 8'h04
`define UHPC_REG_INREQ 8'h08
`define UHPC_REG_CIRQ_EN 8'h0c
`define UHPC_REG_CIRQ_ST 8'h10
`define UHPC_REG_EIRQ_EN 8'h14
`define UHPC_REG_EIRQ_ST 8'h18
`define UHPC_REG_SPEED 8'h1c
`define UHPC_REG_STATUS 8'h20
// Power register fields
`define UHPC_PWR_EN_BIT 0
`define UHPC_PWR_FLT_EN_BIT 1
`define UHPC_PWR_FLT_HIGH_BIT 2
`define UHPC_PWR_ACT_LSB 3
`define UHPC_PWR_EN_HIGH_BIT 5
// Fault actions
`define UHPC_ACT_NONE 2'h0
`define UHPC_ACT_TRI 2'h1
`define UHPC_ACT_LOW 2'h2
`define UHPC_ACT_HIGH 2'h3
// Bus control fields
`define UHPC_BUS_RESET_BIT 0
`define UHPC_BUS_RESUME_BIT 1
`define UHPC_BUS_SUSPEND_BIT 2
`define UHPC_BUS_STATUS_REQ_BIT 3
// Control interrupt fields
`define UHPC_CI_CONNECT 0
`define UHPC_CI_DISCONNECT 1
`define UHPC_CI_POWER_FAULT 2
`define UHPC_CI_RESUME 3
`define UHPC_CI_BABBLE 4
`define UHPC_CI_SOF 5
`define UHPC_CI_WIDTH 6
// Speed codes
`define UHPC_SPEED_UNKNOWN 2'h0
`define UHPC_SPEED_LOW 2'h1
`define UHPC_SPEED_FULL 2'h2
`define UHPC_SPEED_HIGH 2'h3
// Line-state codes driven toward the transceiver
`define UHPC_LINE_IDLE 2'h0
`define UHPC_LINE_RESET 2'h1
`define UHPC_LINE_RESUME 2'h2
`define UHPC_LINE_SUSPEND 2'h3
// End-of-resume low-speed EOP length in ns and cycles at 40 MHz
`define UHPC_CLK_MHZ 40
`define UHPC_EOP_NS 1330
`define UHPC_EOP_CYC ((`UHPC_EOP_NS * `UHPC_CLK_MHZ + 999) / 1000)
`define UHPC_RST_VAL 32'h0000_0000
`endif

// ===== uhpc_flag_bank.v
// Bank of sticky flags with a per-bit mask and clear-on-read.
// Assumes one clock, synchronous reset and a clock enable from the parent.
module uhpc_flag_bank #(
    parameter WIDTH = 8
) (
    input wire clk_i,
    input wire srst_i,
    input wire ce_i,
    input wire [WIDTH-1:0] set_i,
    input wire rd_clr_i,
    input wire [WIDTH-1:0] en_i,
    output reg [WIDTH-1:0] flags_o,
    output wire pend_o
);
    // Sets win over the read-clear so an event in that cycle stays pending
    always @(posedge clk_i)
    begin
        if (srst_i)
            flags_o <= {WIDTH{1'b0}};
        else if (ce_i)
            flags_o <= (rd_clr_i ? {WIDTH{1'b0}} : flags_o) | set_i;
    end

    // Any enabled pending source
    assign pend_o = |(flags_o & en_i);
endmodule // uhpc_flag_bank

// ===== uhpc_port_ctrl.v
// Host port control: power, fault, IN requests, bus signaling, speed, irqs.
// Assumes register port strobes are one cycle and synchronous to REF_CLK_I.
// Notes on behaviour
// - Power control set drives power enable
// - Power control cleared removes power enable
// - Fault ignored while detection is disabled
// - Enabled detection watches fault input
// - Fault applies chosen action to enable
// - IN request bit schedules IN transaction
// - Clearing request cancels unissued transaction
// - Status request issues IN, then interrupt
// - Status requests only on endpoint zero
// - Reset control drives and stops reset
// - Resume control starts resume signaling
// - Resume clear finishes resume sequence
// - Report attached speed low, full, high, unknown
// - Suspend control places bus suspended
// - Separate per-source control interrupt mask
// - Per-endpoint, per-direction endpoint interrupt mask
// - Enabled sources form one interrupt request
// - Control status read returns and clears
`include "uhpc_defs.vh"
module uhpc_port_ctrl #(
    parameter NUM_EP = 8,
    parameter EOP_CYC = `UHPC_EOP_CYC
) (
    input wire REF_CLK_I,
    input wire SRST_I,
    input wire CE_I,
    input wire [7:0] ADDR_I,
    input wire [31:0] WDATA_I,
    input wire WR_I,
    input wire RD_I,
    output reg [31:0] RDATA_O,
    input wire POWER_FAULT_IN_I,
    output reg EXT_POWER_ENABLE_OUT_O,
    output reg EXT_POWER_ENABLE_OUT_OE_N_O,
    output reg [1:0] LINE_STATE_O,
    output reg [NUM_EP-1:0] IN_ISSUE_O,
    output reg STATUS_ISSUE_O,
    input wire [NUM_EP-1:0] IN_TAKEN_I,
    input wire [NUM_EP-1:0] IN_DONE_I,
    input wire [NUM_EP-1:0] OUT_DONE_I,
    input wire STATUS_DONE_I,
    input wire ATTACHED_I,
    input wire SPEED_VALID_I,
    input wire [1:0] SPEED_I,
    input wire CONNECT_EV_I,
    input wire DISCONNECT_EV_I,
    input wire BABBLE_EV_I,
    input wire SOF_EV_I,
    output reg IRQ_O
);
    localparam CIW = `UHPC_CI_WIDTH;
    localparam EPW = 2 * NUM_EP;
    // Bus signaling states
    localparam ST_IDLE = 3'h0;
    localparam ST_RESET = 3'h1;
    localparam ST_RESUME = 3'h2;
    localparam ST_EOP = 3'h3;
    localparam ST_SUSP = 3'h4;

    reg [5:0] power_q;
    reg [3:0] busctl_q;
    reg [NUM_EP-1:0] inreq_q;
    reg status_req_q;
    reg [CIW-1:0] ci_en_q;
    reg [EPW-1:0] ei_en_q;
    reg [2:0] st_q;
    reg [2:0] st_d;
    reg [15:0] eop_cnt_q;
    reg fault_latched_q;
    reg [1:0] speed_q;
    wire [CIW-1:0] ci_flags;
    wire [EPW-1:0] ei_flags;
    wire ci_pend;
    wire ei_pend;
    reg [CIW-1:0] ci_set;
    wire [EPW-1:0] ei_set;
    wire fault_level;
    wire fault_hit;
    wire [1:0] fault_act;
    wire pwr_on;
    reg pwr_level;
    reg pwr_oe_n;

    // Decode a write strobe for one offset
    function wr_hit;
        input [7:0] a;
        input [7:0] off;
        input w;
        begin
            wr_hit = w && (a == off);
        end
    endfunction

    wire wr_power = wr_hit(ADDR_I, `UHPC_REG_POWER, WR_I);
    wire wr_bus = wr_hit(ADDR_I, `UHPC_REG_BUSCTL, WR_I);
    wire wr_inreq = wr_hit(ADDR_I, `UHPC_REG_INREQ, WR_I);
    wire wr_cien = wr_hit(ADDR_I, `UHPC_REG_CIRQ_EN, WR_I);
    wire wr_eien = wr_hit(ADDR_I, `UHPC_REG_EIRQ_EN, WR_I);
    // reads of a status word clear it
    wire rd_cist = wr_hit(ADDR_I, `UHPC_REG_CIRQ_ST, RD_I);
    wire rd_eist = wr_hit(ADDR_I, `UHPC_REG_EIRQ_ST, RD_I);

    // Register writes; power, fault and mask controls
    always @(posedge REF_CLK_I)
    begin
        if (SRST_I)
        begin
            power_q <= 6'h00;
            busctl_q <= 4'h0;
            ci_en_q <= {CIW{1'b0}};
            ei_en_q <= {EPW{1'b0}};
        end
        else if (CE_I)
        begin
            if (wr_power)
                power_q <= WDATA_I[5:0];
            if (wr_bus)
                busctl_q <= {1'b0, WDATA_I[2:0]};
            // control sources masked one by one
            if (wr_cien)
                ci_en_q <= WDATA_I[CIW-1:0];
            // one mask bit per endpoint and direction
            if (wr_eien)
                ei_en_q <= WDATA_I[EPW-1:0];
        end
    end

    // IN requests: software sets or clears, the engine takes them
    genvar g;
    generate
        for (g = 0; g < NUM_EP; g = g + 1)
        begin : g_inreq
            always @(posedge REF_CLK_I)
            begin
                if (SRST_I)
                    inreq_q[g] <= 1'b0;
                else if (CE_I)
                begin
                    // setting the bit schedules an IN transaction
                    // clearing cancels it while still unissued
                    if (wr_inreq)
                        inreq_q[g] <= WDATA_I[g];
                    else if (IN_TAKEN_I[g])
                        inreq_q[g] <= 1'b0;
                end
            end
        end
    endgenerate

    // Issue lines follow pending requests; cancel drops them next cycle
    always @(posedge REF_CLK_I)
    begin
        if (SRST_I)
        begin
            IN_ISSUE_O <= {NUM_EP{1'b0}};
            STATUS_ISSUE_O <= 1'b0;
        end
        else if (CE_I)
        begin
            IN_ISSUE_O <= inreq_q & ~IN_TAKEN_I;
            // status-phase IN on the control endpoint
            STATUS_ISSUE_O <= status_req_q & ~STATUS_DONE_I;
        end
    end

    // status request exists only for endpoint zero, a bit of its own
    always @(posedge REF_CLK_I)
    begin
        if (SRST_I)
            status_req_q <= 1'b0;
        else if (CE_I)
        begin
            if (wr_bus && WDATA_I[`UHPC_BUS_STATUS_REQ_BIT])
                status_req_q <= 1'b1;
            else if (STATUS_DONE_I)
                status_req_q <= 1'b0;
        end
    end

    // Fault polarity and detection gating
    assign fault_level = power_q[`UHPC_PWR_FLT_HIGH_BIT] ? POWER_FAULT_IN_I : ~POWER_FAULT_IN_I;
    // disabled detection ignores the pin entirely
    assign fault_hit = power_q[`UHPC_PWR_FLT_EN_BIT] & fault_level;
    assign fault_act = power_q[`UHPC_PWR_ACT_LSB+1:`UHPC_PWR_ACT_LSB];
    assign pwr_on = power_q[`UHPC_PWR_EN_BIT];

    // Fault holds until software drops detection or power, avoids chatter
    always @(posedge REF_CLK_I)
    begin
        if (SRST_I)
            fault_latched_q <= 1'b0;
        else if (CE_I)
        begin
            if (fault_hit)
                fault_latched_q <= 1'b1;
            else if (!power_q[`UHPC_PWR_FLT_EN_BIT] || !pwr_on)
                fault_latched_q <= 1'b0;
        end
    end

    // Power enable level and drive before the output flops
    always @*
    begin
        // control set asserts enable at the chosen level
        pwr_level = pwr_on ~^ power_q[`UHPC_PWR_EN_HIGH_BIT];
        pwr_oe_n = 1'b0;
        // fault action overrides the manual level
        if (fault_latched_q || fault_hit)
        begin
            case (fault_act)
                `UHPC_ACT_TRI: pwr_oe_n = 1'b1;
                `UHPC_ACT_LOW: pwr_level = 1'b0;
                `UHPC_ACT_HIGH: pwr_level = 1'b1;
                default: pwr_level = pwr_level;
            endcase
        end
    end

    always @(posedge REF_CLK_I)
    begin
        if (SRST_I)
        begin
            EXT_POWER_ENABLE_OUT_O <= 1'b0;
            EXT_POWER_ENABLE_OUT_OE_N_O <= 1'b0;
        end
        else if (CE_I)
        begin
            EXT_POWER_ENABLE_OUT_O <= pwr_level;
            EXT_POWER_ENABLE_OUT_OE_N_O <= pwr_oe_n;
        end
    end

    // Bus signaling sequencer; from idle or suspend, reset outranks resume, resume outranks suspend
    always @*
    begin
        st_d = st_q;
        case (st_q)
            ST_IDLE, ST_SUSP:
            begin
                if (busctl_q[`UHPC_BUS_RESET_BIT])
                    st_d = ST_RESET;
                else if (busctl_q[`UHPC_BUS_RESUME_BIT])
                    st_d = ST_RESUME;
                else if (busctl_q[`UHPC_BUS_SUSPEND_BIT])
                    st_d = ST_SUSP;
                else
                    st_d = ST_IDLE;
            end
            // reset driven exactly while the control is set
            ST_RESET:
                if (!busctl_q[`UHPC_BUS_RESET_BIT])
                    st_d = ST_IDLE;
            // resume signaling runs while the control is set
            ST_RESUME:
                if (!busctl_q[`UHPC_BUS_RESUME_BIT])
                    st_d = ST_EOP;
            // clearing resume finishes with an end-of-resume phase
            ST_EOP:
                if (eop_cnt_q == EOP_CYC - 1)
                    st_d = ST_IDLE;
            default: st_d = ST_IDLE;
        endcase
    end

    always @(posedge REF_CLK_I)
    begin
        if (SRST_I)
        begin
            st_q <= ST_IDLE;
            eop_cnt_q <= 16'h0000;
        end
        else if (CE_I)
        begin
            st_q <= st_d;
            eop_cnt_q <= (st_q == ST_EOP) ? eop_cnt_q + 16'h0001 : 16'h0000;
        end
    end

    // Line state out; suspend state idles the bus suspended
    always @(posedge REF_CLK_I)
    begin
        if (SRST_I)
            LINE_STATE_O <= `UHPC_LINE_IDLE;
        else if (CE_I)
        begin
            case (st_d)
                ST_RESET: LINE_STATE_O <= `UHPC_LINE_RESET;
                ST_RESUME, ST_EOP: LINE_STATE_O <= `UHPC_LINE_RESUME;
                ST_SUSP: LINE_STATE_O <= `UHPC_LINE_SUSPEND;
                default: LINE_STATE_O <= `UHPC_LINE_IDLE;
            endcase
        end
    end

    // speed of attached device as reported by detection
    // unknown while detached or detection unfinished
    always @(posedge REF_CLK_I)
    begin
        if (SRST_I)
            speed_q <= `UHPC_SPEED_UNKNOWN;
        else if (CE_I)
            speed_q <= (ATTACHED_I && SPEED_VALID_I) ? SPEED_I : `UHPC_SPEED_UNKNOWN;
    end

    // Control interrupt sources
    always @*
    begin
        ci_set = {CIW{1'b0}};
        ci_set[`UHPC_CI_CONNECT] = CONNECT_EV_I;
        ci_set[`UHPC_CI_DISCONNECT] = DISCONNECT_EV_I;
        ci_set[`UHPC_CI_POWER_FAULT] = fault_hit & ~fault_latched_q;
        ci_set[`UHPC_CI_RESUME] = (st_q == ST_EOP) && (st_d == ST_IDLE);
        ci_set[`UHPC_CI_BABBLE] = BABBLE_EV_I;
        ci_set[`UHPC_CI_SOF] = SOF_EV_I;
    end

    // endpoint zero IN flag also marks status packet received
    assign ei_set = {OUT_DONE_I, IN_DONE_I | {{(NUM_EP-1){1'b0}}, STATUS_DONE_I}};

    uhpc_flag_bank #(
        .WIDTH(CIW)
    ) u_ci (
        .clk_i(REF_CLK_I),
        .srst_i(SRST_I),
        .ce_i(CE_I),
        .set_i(ci_set),
        .rd_clr_i(rd_cist),
        .en_i(ci_en_q),
        .flags_o(ci_flags),
        .pend_o(ci_pend)
    );

    uhpc_flag_bank #(
        .WIDTH(EPW)
    ) u_ei (
        .clk_i(REF_CLK_I),
        .srst_i(SRST_I),
        .ce_i(CE_I),
        .set_i(ei_set),
        .rd_clr_i(rd_eist),
        .en_i(ei_en_q),
        .flags_o(ei_flags),
        .pend_o(ei_pend)
    );

    // all enabled sources merge into one request
    always @(posedge REF_CLK_I)
    begin
        if (SRST_I)
            IRQ_O <= 1'b0;
        else if (CE_I)
            IRQ_O <= ci_pend | ei_pend;
    end

    // Read data one cycle after the strobe, zero otherwise and when unmapped
    always @(posedge REF_CLK_I)
    begin
        if (SRST_I)
            RDATA_O <= `UHPC_RST_VAL;
        else if (CE_I)
        begin
            RDATA_O <= 32'h0000_0000;
            if (RD_I)
            begin
                case (ADDR_I)
                    `UHPC_REG_POWER: RDATA_O <= {26'h0, power_q};
                    `UHPC_REG_BUSCTL: RDATA_O <= {28'h0, status_req_q, busctl_q[2:0]};
                    `UHPC_REG_INREQ: RDATA_O <= {{(32-NUM_EP){1'b0}}, inreq_q};
                    `UHPC_REG_CIRQ_EN: RDATA_O <= {{(32-CIW){1'b0}}, ci_en_q};
                    `UHPC_REG_CIRQ_ST: RDATA_O <= {{(32-CIW){1'b0}}, ci_flags};
                    `UHPC_REG_EIRQ_EN: RDATA_O <= {{(32-EPW){1'b0}}, ei_en_q};
                    `UHPC_REG_EIRQ_ST: RDATA_O <= {{(32-EPW){1'b0}}, ei_flags};
                    `UHPC_REG_SPEED: RDATA_O <= {30'h0, speed_q};
                    `UHPC_REG_STATUS: RDATA_O <= {28'h0, fault_latched_q, st_q};
                    default: RDATA_O <= 32'h0000_0000;
                endcase
            end
        end
    end
endmodule // uhpc_port_ctrl

// ===== uhpc_props.sv
// Assertions for the host port control block.
// Assumes CE_I is held high and the bench hands EOP_CYC of 3.
`include "uhpc_defs.vh"
module uhpc_props #(
    parameter NUM_EP = 8
) (
    input wire REF_CLK_I,
    input wire SRST_I,
    input wire [7:0] ADDR_I,
    input wire [31:0] WDATA_I,
    input wire WR_I,
    input wire EXT_POWER_ENABLE_OUT_O,
    input wire EXT_POWER_ENABLE_OUT_OE_N_O,
    input wire [1:0] LINE_STATE_O,
    input wire [NUM_EP-1:0] IN_ISSUE_O,
    input wire STATUS_ISSUE_O
);
    default clocking @(posedge REF_CLK_I); endclocking
    default disable iff (SRST_I);
    // Decoded writes; fault detection off so no action can interfere
    wire pwr_wr = WR_I && ADDR_I == `UHPC_REG_POWER && !WDATA_I[1];
    wire bus_wr = WR_I && ADDR_I == `UHPC_REG_BUSCTL;
    wire in_wr = WR_I && ADDR_I == `UHPC_REG_INREQ;
    wire pen = EXT_POWER_ENABLE_OUT_O;
    wire oe_n = EXT_POWER_ENABLE_OUT_OE_N_O;
    AST_PWR_ON: assert property (pwr_wr && WDATA_I[0] && WDATA_I[5]
        |-> ##[1:2] pen && !oe_n) else $error("power enable not raised");
    AST_PWR_OFF: assert property (pwr_wr && !WDATA_I[0] && WDATA_I[5]
        |-> ##[1:2] !pen && !oe_n) else $error("power enable not dropped");
    AST_RST: assert property ($fell(SRST_I)
        |-> !pen && LINE_STATE_O == `UHPC_LINE_IDLE && IN_ISSUE_O == 0)
        else $error("outputs not quiet after reset");
    AST_LINE_RST: assert property (bus_wr && WDATA_I[0]
        |-> ##2 LINE_STATE_O == `UHPC_LINE_RESET) else $error("no reset signaling");
    AST_TAIL: assert property (bus_wr && WDATA_I[1:0] == 2'h0
        && LINE_STATE_O == `UHPC_LINE_RESUME |-> ##1 (LINE_STATE_O == `UHPC_LINE_RESUME)[*2]
        ##[1:8] LINE_STATE_O != `UHPC_LINE_RESUME) else $error("resume end wrong");
    AST_SUSP: assert property (bus_wr && WDATA_I[2:0] == 3'h4
        && LINE_STATE_O != `UHPC_LINE_RESUME |-> ##2 LINE_STATE_O == `UHPC_LINE_SUSPEND)
        else $error("bus not suspended");
    AST_IN_SET: assert property (in_wr && WDATA_I[0]
        |-> ##2 IN_ISSUE_O[0]) else $error("IN request not issued");
    AST_IN_CLR: assert property (in_wr && !WDATA_I[0]
        |-> ##2 !IN_ISSUE_O[0]) else $error("IN request not cancelled");
    AST_STAT: assert property (bus_wr && WDATA_I[3]
        |-> ##[1:2] STATUS_ISSUE_O) else $error("status IN not issued");
endmodule // uhpc_props
bind uhpc_port_ctrl uhpc_props #(.NUM_EP(NUM_EP)) uhpc_props_i (
    .REF_CLK_I(REF_CLK_I),
    .SRST_I(SRST_I),
    .ADDR_I(ADDR_I),
    .WDATA_I(WDATA_I),
    .WR_I(WR_I),
    .EXT_POWER_ENABLE_OUT_O(EXT_POWER_ENABLE_OUT_O),
    .EXT_POWER_ENABLE_OUT_OE_N_O(EXT_POWER_ENABLE_OUT_OE_N_O),
    .LINE_STATE_O(LINE_STATE_O),
    .IN_ISSUE_O(IN_ISSUE_O),
    .STATUS_ISSUE_O(STATUS_ISSUE_O)
);

// ===== uhpc_dev_model.sv
// Attached-device model: answers IN and status requests after a delay.
// Assumes request levels from the host port on the same clock.
module uhpc_dev_model (
    input wire clk_i,
    input wire srst_i,
    input wire slow_i,
    input wire [7:0] in_issue_i,
    input wire status_issue_i,
    output logic [7:0] in_taken_o,
    output logic [7:0] in_done_o,
    output logic status_done_o
);
    timeunit 1ns;
    timeprecision 100ps;
    int wait_q;
    // Answer all pending requests when the delay runs out; slow mode
    // leaves room for the host to cancel first
    always @(posedge clk_i)
    begin
        in_taken_o <= 8'h00;
        in_done_o <= 8'h00;
        status_done_o <= 1'b0;
        if (srst_i || (in_issue_i == 8'h00 && !status_issue_i))
            wait_q <= 0;
        else if (wait_q == (slow_i ? 10 : 3))
        begin
            in_taken_o <= in_issue_i;
            in_done_o <= in_issue_i;
            status_done_o <= status_issue_i;
            wait_q <= 0;
        end
        else
            wait_q <= wait_q + 1;
    end
endmodule // uhpc_dev_model

// ===== usb_host_port_control_test.sv
// Testbench for the host port control block.
// Assumes the device model answers requests; CE_I held high.
`include "uhpc_defs.vh"
module usb_host_port_control_test;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk = 0, rst = 1, wr = 0, rd = 0, flt = 1, slow = 1, att = 0, sv = 0, con = 0;
    logic dis = 0, bab = 0;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata;
    logic [1:0] spd = 2'h0, line;
    logic pen, poe_n, siss, sdn, irq;
    logic [7:0] iss, tkn, idn;
    int num_errors = 0, tests_run = 0, cyc = 0;
    uhpc_port_ctrl #(.EOP_CYC(3)) uhpc_port_ctrl_i (.REF_CLK_I(clk), .SRST_I(rst),
        .CE_I(1'b1), .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr), .RD_I(rd), .RDATA_O(rdata),
        .POWER_FAULT_IN_I(flt), .EXT_POWER_ENABLE_OUT_O(pen),
        .EXT_POWER_ENABLE_OUT_OE_N_O(poe_n), .LINE_STATE_O(line), .IN_ISSUE_O(iss),
        .STATUS_ISSUE_O(siss), .IN_TAKEN_I(tkn), .IN_DONE_I(idn), .OUT_DONE_I(8'h00),
        .STATUS_DONE_I(sdn), .ATTACHED_I(att), .SPEED_VALID_I(sv), .SPEED_I(spd),
        .CONNECT_EV_I(con), .DISCONNECT_EV_I(dis), .BABBLE_EV_I(bab), .SOF_EV_I(1'b0),
        .IRQ_O(irq));
    uhpc_dev_model uhpc_dev_model_i (.clk_i(clk), .srst_i(rst), .slow_i(slow),
        .in_issue_i(iss), .status_issue_i(siss), .in_taken_o(tkn), .in_done_o(idn),
        .status_done_o(sdn));
    // Free-running clock, 25 ns
    initial
    begin
        forever #12.5 clk = ~clk;
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wrr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    // Read data stands only in the cycle after the strobe
    task automatic rdc(input logic [7:0] a, input logic [31:0] e);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        @(negedge clk);
        chk(rdata, e);
    endtask
    // Bounded wait until the far side has answered everything
    task automatic drain;
        // Issue lines rise two edges after the write, so look only then
        repeat (2) @(negedge clk);
        for (int k = 0; k < 40 && (iss !== 8'h00 || siss !== 1'b0); k++)
            @(negedge clk);
        repeat (3) @(negedge clk);
    endtask
    task automatic finish_test;
        $display("comparisons %0d, mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    // Hang guard, well above the few hundred cycles the tests need
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 4000)
        begin
            num_errors++;
            finish_test;
        end
    end
    initial
    begin
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        rdc(`UHPC_REG_SPEED, 32'h0);
        // Reset leaves the enable active low and off, so the pin idles high
        chk(32'({poe_n, pen}), 32'h1);
        wrr(`UHPC_REG_POWER, 32'h21);
        repeat (3) @(negedge clk);
        chk(32'({poe_n, pen}), 32'h1);
        wrr(`UHPC_REG_POWER, 32'h20);
        repeat (3) @(negedge clk);
        chk(32'({poe_n, pen}), 32'h0);
        $display("power test done");
        // Each fault action in turn, then detection off with the pin faulty
        wrr(`UHPC_REG_CIRQ_EN, 32'h4);
        for (int i = 0; i < 5; i++)
        begin
            @(posedge clk) flt <= 1'b1;
            wrr(`UHPC_REG_POWER, 32'h20);
            wrr(`UHPC_REG_POWER, i == 4 ? 32'h21 : 32'h23 | 32'(i << 3));
            flt <= 1'b0;
            repeat (5) @(negedge clk);
            if (i != 1)
                chk(32'(pen), 32'(i != 2));
            chk(32'(poe_n), 32'(i == 1));
            chk(32'(irq), 32'(i != 4));
            rdc(`UHPC_REG_CIRQ_ST, i == 4 ? 32'h0 : 32'h4);
        end
        rdc(`UHPC_REG_CIRQ_ST, 32'h0);
        @(posedge clk) flt <= 1'b1;
        $display("fault test done");
        // Slow far side, so the cancel lands before the IN goes out
        wrr(`UHPC_REG_EIRQ_EN, 32'h2);
        wrr(`UHPC_REG_INREQ, 32'h3);
        repeat (2) @(negedge clk);
        chk(32'(iss), 32'h3);
        wrr(`UHPC_REG_INREQ, 32'h1);
        repeat (2) @(negedge clk);
        chk(32'(iss), 32'h1);
        drain;
        chk(32'(irq), 32'h0);
        rdc(`UHPC_REG_EIRQ_ST, 32'h1);
        wrr(`UHPC_REG_INREQ, 32'h2);
        drain;
        chk(32'(irq), 32'h1);
        rdc(`UHPC_REG_EIRQ_ST, 32'h2);
        @(posedge clk) slow <= 1'b0;
        wrr(`UHPC_REG_BUSCTL, 32'h8);
        drain;
        rdc(`UHPC_REG_EIRQ_ST, 32'h1);
        $display("transaction test done");
        // Reset, resume, suspend; holds kept short in place of milliseconds
        for (int c = 1; c < 5; c = c * 2)
        begin
            wrr(`UHPC_REG_BUSCTL, 32'(c));
            repeat (2) @(negedge clk);
            chk(32'(line), c == 4 ? 32'h3 : 32'(c));
            wrr(`UHPC_REG_BUSCTL, 32'h0);
            repeat (2) @(negedge clk);
            chk(32'(line), c == 2 ? 32'h2 : 32'h0);
            repeat (6) @(negedge clk);
            chk(32'(line), 32'h0);
        end
        rdc(`UHPC_REG_CIRQ_ST, 32'h8);
        $display("bus test done");
        // Connect, disconnect and babble masked; speed unknown until valid
        @(posedge clk);
        att <= 1'b1;
        con <= 1'b1;
        dis <= 1'b1;
        bab <= 1'b1;
        @(posedge clk);
        con <= 1'b0;
        dis <= 1'b0;
        bab <= 1'b0;
        rdc(`UHPC_REG_SPEED, 32'h0);
        chk(32'(irq), 32'h0);
        rdc(`UHPC_REG_CIRQ_ST, 32'h13);
        @(posedge clk) sv <= 1'b1;
        for (int s = 1; s < 4; s++)
        begin
            @(posedge clk) spd <= 2'(s);
            rdc(`UHPC_REG_SPEED, 32'(s));
        end
        $display("speed test done");
        finish_test;
    end
endmodule // usb_host_port_control_test
